// *** hw/gsl_sleep_load.sv ***
// gauge sleep, pre-sleep calibration, wake and load model, apb configured
// assumes measurements on pclk; the two bus lines are raw pins
//
// How it works
// - bus idle timeout defaults to 5 s, never below 2 s.
// - calibrate before sleep only if temperature, current and bus idle met.
// - calibration temperature floor, 0.1 C units, default 50.
// - calibration ceiling default 450; outside window, no calibration.
// - asleep, update voltage and temperature each voltage wake interval.
// - asleep, update current each current wake interval, default 20 s.
// - after current update, sleep again unless current at or beyond idle limit.
// - model type 0 constant current, 1 constant power.
// - current model codes 0 to 6 pick current sources.
// - power model codes 0 to 6 pick power sources.
// - load select defaults to 3, average current or power.
// - fixed rate current only with code 6, model 0.
// - fixed rate power only with code 6, model 1.
// - end of discharge voltage marks zero chemical capacity.
// - reserve at no-load rate when select 0, load rate when 1.
// - reserve charge only with model 0 and milliamp-hour units.
// - reserve charge defaults to 0, reserve disabled.
// - reserve energy only with model type 1.
// - sleep entry also needs low-power enable.
// - low-power enable does not gate pre-sleep calibration.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "gsl_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module gsl_sleep_load
    import gsl_pkg::*;
#(
    parameter int TICK_CYCLES = `GSL_PCLK_HZ / 1000 * `GSL_TICK_MS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_clk_pin,
    input wire logic bus_data_pin,
    input wire logic signed [15:0] temperature,
    input wire logic signed [15:0] current,
    input wire logic signed [15:0] avg_current,
    input wire logic [15:0] voltage,
    input wire logic signed [15:0] prev_dsg_current,
    input wire logic signed [15:0] pres_dsg_current,
    input wire logic signed [15:0] prev_dsg_power,
    input wire logic signed [15:0] pres_dsg_power,
    input wire logic [15:0] design_capacity,
    input wire logic [15:0] design_energy,
    input wire logic signed [15:0] at_rate_value,
    input wire logic cal_done,
    input wire logic meas_done,
    output logic counter_offset_cal,
    output logic volt_meas_req,
    output logic curr_meas_req,
    output logic sleep_active,
    output logic signed [31:0] load_rate,
    output logic signed [31:0] reserve_rate,
    output logic [15:0] reserve_capacity,
    output logic [15:0] term_voltage_out,
    output logic soc_source_select
);
    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [`GSL_CFG_WIDTH-1:0] config_word;
    gsl_word_t bus_idle_time;
    gsl_word_t cal_temp_low;
    gsl_word_t cal_temp_high;
    gsl_word_t idle_current_limit;
    gsl_word_t volt_wake_time;
    gsl_word_t curr_wake_time;
    logic [2:0] load_select;
    gsl_word_t fixed_rate_current;
    gsl_word_t fixed_rate_power;
    gsl_word_t term_voltage;
    gsl_word_t reserve_charge;
    gsl_word_t reserve_energy;
    gsl_word_t cal_count;

    wire low_power_en = config_word[`GSL_CFG_LOW_POWER];
    wire model_type = config_word[`GSL_CFG_MODEL_TYPE];
    wire reserve_comp_select = config_word[`GSL_CFG_RES_COMP];
    wire capacity_units_mode = config_word[`GSL_CFG_CAP_UNITS];

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state: pready rises on the second access cycle, so that
    // read data and the error flag come straight from flip-flops
    wire apb_access = psel && penable && !pready;
    wire apb_done = psel && penable && pready;
    wire wr_en = apb_done && pwrite;
    wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [15:0] wdata = pwdata[15:0];

    wire hit_config = (paddr == `GSL_OFF_CONFIG);
    wire hit_bus_idle = (paddr == `GSL_OFF_BUS_IDLE);
    wire hit_t_low = (paddr == `GSL_OFF_CAL_T_LOW);
    wire hit_t_high = (paddr == `GSL_OFF_CAL_T_HIGH);
    wire hit_idle_curr = (paddr == `GSL_OFF_IDLE_CURR);
    wire hit_volt_wake = (paddr == `GSL_OFF_VOLT_WAKE);
    wire hit_curr_wake = (paddr == `GSL_OFF_CURR_WAKE);
    wire hit_load_sel = (paddr == `GSL_OFF_LOAD_SEL);
    wire hit_fix_curr = (paddr == `GSL_OFF_FIX_CURR);
    wire hit_fix_power = (paddr == `GSL_OFF_FIX_POWER);
    wire hit_term = (paddr == `GSL_OFF_TERM_VOLT);
    wire hit_res_charge = (paddr == `GSL_OFF_RES_CHARGE);
    wire hit_res_energy = (paddr == `GSL_OFF_RES_ENERGY);
    wire hit_status = (paddr == `GSL_OFF_STATUS);
    wire hit_load_rate = (paddr == `GSL_OFF_LOAD_RATE);
    wire hit_cal_count = (paddr == `GSL_OFF_CAL_COUNT);
    wire hit_ro = hit_status || hit_load_rate || hit_cal_count;
    wire hit_rw = hit_config || hit_bus_idle || hit_t_low || hit_t_high ||
        hit_idle_curr || hit_volt_wake || hit_curr_wake || hit_load_sel ||
        hit_fix_curr || hit_fix_power || hit_term || hit_res_charge ||
        hit_res_energy;
    // writes to read-only words are refused as well as unmapped ones
    wire bad_access = !(hit_rw || (hit_ro && !pwrite));

    function automatic gsl_word_t merge(input gsl_word_t old_v,
            input gsl_word_t new_v, input gsl_word_t mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_word <= `GSL_RST_CONFIG;
            bus_idle_time <= `GSL_RST_BUS_IDLE;
            cal_temp_low <= `GSL_RST_CAL_T_LOW;
            cal_temp_high <= `GSL_RST_CAL_T_HIGH;
            idle_current_limit <= `GSL_RST_IDLE_CURR;
            volt_wake_time <= `GSL_RST_VOLT_WAKE;
            curr_wake_time <= `GSL_RST_CURR_WAKE;
            load_select <= `GSL_RST_LOAD_SEL;
            fixed_rate_current <= 16'h0000;
            fixed_rate_power <= 16'h0000;
            term_voltage <= 16'h0000;
            reserve_charge <= `GSL_RST_RESERVE;
            reserve_energy <= `GSL_RST_RESERVE;
        end else if (wr_en && !bad_access) begin
            if (hit_config && pstrb[0])
                config_word <= wdata[`GSL_CFG_WIDTH-1:0];
            if (hit_bus_idle)
                bus_idle_time <= merge(bus_idle_time, wdata, wmask);
            if (hit_t_low)
                cal_temp_low <= merge(cal_temp_low, wdata, wmask);
            if (hit_t_high)
                cal_temp_high <= merge(cal_temp_high, wdata, wmask);
            if (hit_idle_curr)
                idle_current_limit <= merge(idle_current_limit, wdata,
                    wmask);
            if (hit_volt_wake)
                volt_wake_time <= merge(volt_wake_time, wdata, wmask);
            if (hit_curr_wake)
                curr_wake_time <= merge(curr_wake_time, wdata, wmask);
            if (hit_load_sel && pstrb[0])
                load_select <= wdata[2:0];
            if (hit_fix_curr)
                fixed_rate_current <= merge(fixed_rate_current, wdata,
                    wmask);
            if (hit_fix_power)
                fixed_rate_power <= merge(fixed_rate_power, wdata, wmask);
            if (hit_term)
                term_voltage <= merge(term_voltage, wdata, wmask);
            if (hit_res_charge)
                reserve_charge <= merge(reserve_charge, wdata, wmask);
            if (hit_res_energy)
                reserve_energy <= merge(reserve_energy, wdata, wmask);
        end
    end

    // ************************************************************
    // pin synchronisers and time base
    // ************************************************************
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [24:0] pre_cnt;
    logic sec_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync <= 2'b00;
            data_sync <= 2'b00;
        end else begin
            clk_sync <= {clk_sync[0], bus_clk_pin};
            data_sync <= {data_sync[0], bus_data_pin};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= '0;
            sec_tick <= 1'b0;
        end else if (pre_cnt == 25'(TICK_CYCLES - 1)) begin
            pre_cnt <= '0;
            sec_tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 25'h1;
            sec_tick <= 1'b0;
        end
    end

    // ************************************************************
    // sleep conditions
    // ************************************************************
    // a short timeout would trip sleep on ordinary bus gaps, hence the floor
    wire [15:0] idle_eff = (bus_idle_time < `GSL_MIN_BUS_IDLE) ?
        `GSL_MIN_BUS_IDLE : bus_idle_time;
    wire [15:0] idle_limit = idle_eff + 16'h0001; // strictly more than
    wire lines_low = !clk_sync[1] && !data_sync[1];
    wire [15:0] volt_limit = (volt_wake_time == 16'h0000) ? 16'h0001 :
        volt_wake_time;
    wire [15:0] curr_limit = (curr_wake_time == 16'h0000) ? 16'h0001 :
        curr_wake_time;
    wire signed [15:0] i_lim = $signed(idle_current_limit);
    wire curr_idle = (current < i_lim) && (current > -i_lim);
    wire temp_ok = (temperature >= $signed(cal_temp_low)) &&
        (temperature <= $signed(cal_temp_high));

    logic bus_idle;
    logic cal_this_idle;
    logic bus_expire;
    logic volt_expire;
    logic curr_expire;
    gsl_state_t state;
    gsl_state_t next_state;

    wire sleeping = (state == GSL_SLEEP);
    wire idle_ready = bus_idle && curr_idle;

    gsl_sec_timer u_bus_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(lines_low),
        .tick(sec_tick),
        .limit(idle_limit),
        .expire(bus_expire)
    );

    gsl_sec_timer u_volt_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(sleeping),
        .tick(sec_tick),
        .limit(volt_limit),
        .expire(volt_expire)
    );

    gsl_sec_timer u_curr_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(sleeping),
        .tick(sec_tick),
        .limit(curr_limit),
        .expire(curr_expire)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_idle <= 1'b0;
        end else if (!lines_low) begin
            bus_idle <= 1'b0;
        end else if (bus_expire) begin
            bus_idle <= 1'b1;
        end
    end

    // ************************************************************
    // sleep state machine
    // ************************************************************
    // calibration is run once per idle episode, so a stay-awake current
    // excursion does not cost a second calibration on re-entry
    always_comb begin
        next_state = state;
        unique case (state)
            GSL_AWAKE: begin
                if (idle_ready && temp_ok && !cal_this_idle) begin
                    next_state = GSL_CAL;
                end else if (idle_ready && low_power_en) begin
                    next_state = GSL_SLEEP;
                end
            end
            GSL_CAL: begin
                if (cal_done) begin
                    next_state = GSL_AWAKE;
                end
            end
            GSL_SLEEP: begin
                if (!bus_idle) begin
                    next_state = GSL_AWAKE;
                end else if (curr_expire) begin
                    next_state = GSL_MEAS;
                end
            end
            GSL_MEAS: begin
                if (meas_done) begin
                    next_state = curr_idle ? GSL_SLEEP : GSL_AWAKE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= GSL_AWAKE;
            cal_this_idle <= 1'b0;
            cal_count <= 16'h0000;
        end else begin
            state <= next_state;
            if (!bus_idle) begin
                cal_this_idle <= 1'b0;
            end else if (state == GSL_CAL && cal_done) begin
                cal_this_idle <= 1'b1;
            end
            if (state == GSL_CAL && cal_done) begin
                cal_count <= cal_count + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_offset_cal <= 1'b0;
            curr_meas_req <= 1'b0;
            volt_meas_req <= 1'b0;
            sleep_active <= 1'b0;
        end else begin
            counter_offset_cal <= (state == GSL_AWAKE) &&
                (next_state == GSL_CAL);
            curr_meas_req <= sleeping && (next_state == GSL_MEAS);
            volt_meas_req <= sleeping && volt_expire;
            sleep_active <= (next_state == GSL_SLEEP);
        end
    end

    // ************************************************************
    // load model
    // ************************************************************
    wire [2:0] sel_eff = (load_select > 3'h6) ? 3'h3 : load_select;
    wire signed [31:0] i_times_v = current * $signed({1'b0, voltage});
    wire signed [31:0] avg_times_v = avg_current * $signed({1'b0, voltage});
    wire signed [31:0] uw_scale = `GSL_UW_PER_10MW;
    wire signed [31:0] pwr_inst = i_times_v / uw_scale;
    wire signed [31:0] pwr_avg = avg_times_v / uw_scale;
    wire [15:0] cap_fifth = design_capacity / 16'h0005;
    wire [15:0] energy_fifth = design_energy / 16'h0005;
    logic signed [31:0] rate_cc;
    logic signed [31:0] rate_cp;

    always_comb begin
        unique case (sel_eff)
            3'h0: rate_cc = 32'(prev_dsg_current);
            3'h1: rate_cc = 32'(pres_dsg_current);
            3'h2: rate_cc = 32'(current);
            3'h4: rate_cc = 32'(cap_fifth);
            3'h5: rate_cc = 32'(at_rate_value);
            3'h6: rate_cc = 32'(fixed_rate_current);
            default: rate_cc = 32'(avg_current);
        endcase
    end

    always_comb begin
        unique case (sel_eff)
            3'h0: rate_cp = 32'(prev_dsg_power);
            3'h1: rate_cp = 32'(pres_dsg_power);
            3'h2: rate_cp = pwr_inst;
            3'h4: rate_cp = 32'(energy_fifth);
            3'h5: rate_cp = 32'(at_rate_value);
            3'h6: rate_cp = 32'(fixed_rate_power);
            default: rate_cp = pwr_avg;
        endcase
    end

    wire signed [31:0] next_load_rate = model_type ? rate_cp : rate_cc;
    wire [15:0] next_reserve = model_type ? reserve_energy :
        (!capacity_units_mode ? reserve_charge : 16'h0000);
    wire signed [31:0] next_reserve_rate = reserve_comp_select ?
        next_load_rate : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_rate <= '0;
            reserve_rate <= '0;
            reserve_capacity <= '0;
            term_voltage_out <= '0;
            soc_source_select <= 1'b0;
        end else begin
            load_rate <= next_load_rate;
            reserve_rate <= next_reserve_rate;
            reserve_capacity <= next_reserve;
            term_voltage_out <= term_voltage;
            soc_source_select <= config_word[`GSL_CFG_SOC_SRC];
        end
    end

    // ************************************************************
    // read back
    // ************************************************************
    wire [15:0] status_word = {10'h000, temp_ok, curr_idle, bus_idle,
        cal_this_idle, state};
    wire [31:0] rd_mux =
        hit_config ? 32'(config_word) :
        hit_bus_idle ? 32'(bus_idle_time) :
        hit_t_low ? 32'(cal_temp_low) :
        hit_t_high ? 32'(cal_temp_high) :
        hit_idle_curr ? 32'(idle_current_limit) :
        hit_volt_wake ? 32'(volt_wake_time) :
        hit_curr_wake ? 32'(curr_wake_time) :
        hit_load_sel ? 32'(load_select) :
        hit_fix_curr ? 32'(fixed_rate_current) :
        hit_fix_power ? 32'(fixed_rate_power) :
        hit_term ? 32'(term_voltage) :
        hit_res_charge ? 32'(reserve_charge) :
        hit_res_energy ? 32'(reserve_energy) :
        hit_status ? 32'(status_word) :
        hit_load_rate ? load_rate :
        hit_cal_count ? 32'(cal_count) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_access;
            prdata <= (apb_access && !pwrite && !bad_access) ? rd_mux : '0;
            pslverr <= apb_access && bad_access;
        end
    end
endmodule

`default_nettype wire

// *** hw/gsl_defines.svh ***
// offsets, field positions, reset values and timing counts of the gauge
// sleep and load model block; included by the gsl_sleep_load module only
`ifndef GSL_DEFINES_SVH
`define GSL_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define GSL_OFF_CONFIG 12'h000
`define GSL_OFF_BUS_IDLE 12'h004
`define GSL_OFF_CAL_T_LOW 12'h008
`define GSL_OFF_CAL_T_HIGH 12'h00c
`define GSL_OFF_IDLE_CURR 12'h010
`define GSL_OFF_VOLT_WAKE 12'h014
`define GSL_OFF_CURR_WAKE 12'h018
`define GSL_OFF_LOAD_SEL 12'h01c
`define GSL_OFF_FIX_CURR 12'h020
`define GSL_OFF_FIX_POWER 12'h024
`define GSL_OFF_TERM_VOLT 12'h028
`define GSL_OFF_RES_CHARGE 12'h02c
`define GSL_OFF_RES_ENERGY 12'h030
`define GSL_OFF_STATUS 12'h034
`define GSL_OFF_LOAD_RATE 12'h038
`define GSL_OFF_CAL_COUNT 12'h03c

// ************************************************************
// config word fields
// ************************************************************
`define GSL_CFG_LOW_POWER 0
`define GSL_CFG_MODEL_TYPE 1
`define GSL_CFG_RES_COMP 2
`define GSL_CFG_CAP_UNITS 3
`define GSL_CFG_SOC_SRC 4
`define GSL_CFG_WIDTH 5

// ************************************************************
// reset values
// ************************************************************
`define GSL_RST_CONFIG 5'h00
`define GSL_RST_BUS_IDLE 16'h0005
`define GSL_MIN_BUS_IDLE 16'h0002
`define GSL_RST_CAL_T_LOW 16'h0032
`define GSL_RST_CAL_T_HIGH 16'h01c2
`define GSL_RST_IDLE_CURR 16'h000a
`define GSL_RST_VOLT_WAKE 16'h0005
`define GSL_RST_CURR_WAKE 16'h0014
`define GSL_RST_LOAD_SEL 3'h3
`define GSL_RST_RESERVE 16'h0000

// ************************************************************
// timing
// ************************************************************
`define GSL_PCLK_HZ 25000000
`define GSL_TICK_MS 1000
`define GSL_UW_PER_10MW 10000

`endif

// *** hw/gsl_pkg.sv ***
// types shared by the gauge sleep and load model block
// assumes gsl_defines.svh sits on the include path
package gsl_pkg;
    typedef logic [15:0] gsl_word_t;
    typedef enum logic [1:0] {
        GSL_AWAKE,
        GSL_CAL,
        GSL_SLEEP,
        GSL_MEAS
    } gsl_state_t;
endpackage

// *** hw/gsl_sec_timer.sv ***
// interval timer: one-cycle expire every limit ticks while run is high
// assumes limit of at least one and tick a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module gsl_sec_timer
    import gsl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic tick,
    input wire gsl_word_t limit,
    output logic expire
);
    gsl_word_t count;
    wire at_end = (count >= limit - 16'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            expire <= 1'b0;
        end else if (!run) begin
            count <= 16'h0000;
            expire <= 1'b0;
        end else if (tick && at_end) begin
            count <= 16'h0000;
            expire <= 1'b1;
        end else begin
            count <= tick ? count + 16'h0001 : count;
            expire <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// *** verif/gsl_sleep_load_monitor.sv ***
// port assertions for the gauge sleep and load model block
// assumes one pclk domain with asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module gsl_sleep_load_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic counter_offset_cal,
    input wire logic volt_meas_req,
    input wire logic curr_meas_req,
    input wire logic sleep_active,
    input wire logic signed [31:0] load_rate,
    input wire logic signed [31:0] reserve_rate
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    a_ready_wait: assert property (s_access |=> pready)
        else $error("access not answered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_idle_quiet: assert property (!pready |-> !pslverr && prdata == 0)
        else $error("response without ready");
    a_cal_pulse: assert property (
        counter_offset_cal |=> !counter_offset_cal) else $error("cal held");
    a_cal_awake: assert property (
        counter_offset_cal |-> !sleep_active) else $error("cal while asleep");
    a_volt_asleep: assert property (
        volt_meas_req |-> sleep_active || $past(sleep_active))
        else $error("voltage wake while awake");
    a_curr_leave: assert property (
        curr_meas_req |-> ##[0:2] !sleep_active) else $error("no wake");
    a_res_follow: assert property (
        reserve_rate != 0 |-> reserve_rate == load_rate ||
        reserve_rate == $past(load_rate)) else $error("reserve rate odd");
endmodule
bind gsl_sleep_load gsl_sleep_load_monitor mon (.*);
`default_nettype wire

// *** verif/gsl_host_model.sv ***
// management bus host: toggles both lines while talking
// assumes talk is driven on pclk; a detached host leaves both lines low
`timescale 1ns/1ps
`default_nettype none
module gsl_host_model (
    input wire logic pclk,
    input wire logic talk,
    output logic bus_clk_pin,
    output logic bus_data_pin
);
    // both lines low when silent, which the gauge reads as idle
    always_ff @(posedge pclk) begin
        // no reset here: an unknown start must not stick while talking
        bus_clk_pin <= talk & (bus_clk_pin !== 1'b1);
        bus_data_pin <= talk & (bus_clk_pin === 1'b1);
    end
endmodule
`default_nettype wire

// *** verif/gsl_sleep_load_test.sv ***
// self-checking bench for the gauge sleep and load model block
// assumes a 1 s tick shortened to TK cycles
`timescale 1ns/1ps
`default_nettype none
module gsl_sleep_load_test;
    import gsl_pkg::*;
    localparam int TK = 20;
    localparam logic [15:0] rv[8] = '{0, 5, 50, 450, 10, 5, 20, 3};
    logic pclk, presetn, psel, penable, pwrite, talk, cal_done, meas_done;
    logic pready, pslverr, bus_clk_pin, bus_data_pin, soc_source_select;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic signed [15:0] temperature, current, avg_current, at_rate_value;
    logic signed [15:0] prev_dsg_current, pres_dsg_current;
    logic signed [15:0] prev_dsg_power, pres_dsg_power;
    logic [15:0] voltage, design_capacity, design_energy;
    logic [15:0] reserve_capacity, term_voltage_out;
    logic counter_offset_cal, volt_meas_req, curr_meas_req, sleep_active;
    logic signed [31:0] load_rate, reserve_rate, x;
    logic [32:0] notes[$];
    logic [32:0] e;
    logic [15:0] wv[5];
    integer seed;
    int n_errors, n_checks, t;
    gsl_sleep_load #(.TICK_CYCLES(TK)) dut (.*);
    gsl_host_model host (.pclk(pclk), .talk(talk),
        .bus_clk_pin(bus_clk_pin), .bus_data_pin(bus_data_pin));
    // ****************
    // tasks
    // ****************
    task automatic fail(input string m);
        n_errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] v);
        n_checks++;
        if (g !== v) fail("value");
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] ex);
        if (!w) notes.push_back(ex);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        n_checks++;
        if (s !== 1'b1) fail("no event");
    endtask
    function automatic logic [15:0] rnd();
        return 16'($random(seed)) & 16'h3fff;
    endfunction
    function automatic logic signed [31:0] rate(input int m, input int c);
        case (c)
            0: return m ? prev_dsg_power : prev_dsg_current;
            1: return m ? pres_dsg_power : pres_dsg_current;
            2: return m ? current * $signed({1'b0, voltage}) / 10000 : current;
            3: return m ? avg_current * $signed({1'b0, voltage}) / 10000
                        : avg_current;
            4: return m ? {16'h0, design_energy} / 5 : design_capacity / 5;
            5: return at_rate_value;
            6: return m ? wv[1] : wv[0];
            default: return rate(m, 3);
        endcase
    endfunction
    // read results are compared in arrival order
    always @(posedge pclk) begin
        if (pready === 1'b1 && psel && !pwrite) begin
            e = notes.pop_front();
            n_checks++;
            if (pslverr !== e[32] || (!e[32] && prdata !== e[31:0]))
                fail("read");
        end
    end
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail("timeout");
        close_out();
    end
    initial begin
        seed = 32'h1d096fc4;
        {presetn, psel, penable, pwrite, cal_done, meas_done} = '0;
        {paddr, pwdata, pstrb, talk, temperature} = {48'h3, 1'b1, 16'sd250};
        {current, avg_current, voltage, prev_dsg_current, pres_dsg_current,
         prev_dsg_power, pres_dsg_power, design_capacity, design_energy,
         at_rate_value} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rv[i])
            apb(0, 12'(4 * i), 0, 33'(rv[i]));
        apb(0, 12'h02c, 0, {1'b0, 32'h0});
        apb(0, 12'h040, 0, {1'b1, 32'h0});
        for (int m = 0; m < 2; m++)
            for (int c = 0; c < 8; c++) begin
                {current, avg_current, voltage, prev_dsg_current,
                 pres_dsg_current, prev_dsg_power, pres_dsg_power,
                 design_capacity, design_energy, at_rate_value} <= {rnd(),
                 rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
                for (int i = 0; i < 5; i++) begin
                    wv[i] = rnd();
                    apb(1, 12'h020 + 12'(4 * i), {16'h0, wv[i]}, 0);
                end
                apb(1, 12'h000, {27'h0, 3'(c), m[0], 1'b0}, 0);
                apb(1, 12'h01c, c, 0);
                repeat (3) @(posedge pclk);
                x = rate(m, c);
                chk(load_rate, x);
                chk(reserve_rate, c[0] ? x : 0);
                chk(reserve_capacity, m ? wv[4] : (c[1] ? 0 : wv[3]));
                chk(term_voltage_out, wv[2]);
                chk(soc_source_select, c[2]);
            end
        apb(1, 12'h000, 32'h1, 0);
        current <= 16'sd0;
        talk <= 1'b0;
        wait_hi(counter_offset_cal, 10 * TK, t);
        chk(t >= 5 * TK, 1);
        cal_done <= 1'b1;
        @(posedge pclk);
        cal_done <= 1'b0;
        wait_hi(sleep_active, 10, t);
        wait_hi(volt_meas_req, 6 * TK, t);
        for (int k = 0; k < 2; k++) begin
            wait_hi(curr_meas_req, 21 * TK, t);
            current <= k ? 16'sd500 : 16'sd0;
            meas_done <= 1'b1;
            @(posedge pclk);
            meas_done <= 1'b0;
            repeat (3) @(posedge pclk);
            chk(sleep_active, !k);
        end
        close_out();
    end
endmodule
`default_nettype wire
